// [verilog/epv_event_vector.v]
`include "epv_defines.vh"

// Behaviour
// (RULE1) reset ranks first, handler at fixed 0x8000_0000, no return address
// (RULE2) debug halt ranks second, handler from debug unit, saves first non-completed
// (RULE3) unrecoverable exception ranks third, base+0x00, saves offending pc
// (RULE4) protection unit multiple hit ranks fourth, base+0x04
// (RULE5) data bus error fifth base+0x08, instruction bus error sixth base+0x0c
// (RULE6) non-maskable interrupt seventh, base+0x10, saves first non-completed
// (RULE7) interrupt levels 3..0 rank 8..11, autovectored, save first non-completed
// (RULE8) bad instruction address twelfth, base+0x14, saves offending pc
// (RULE9) itlb miss thirteenth base+0x50, itlb protection fourteenth base+0x18
// (RULE10) breakpoint fifteenth, base+0x1c, saves first non-completed
// (RULE11) illegal, unimplemented, privilege rank 16..18 at base+0x20/0x24/0x28
// (RULE12) floating-point slot 19 at 0x2c reserved, never raised
// (RULE13) coprocessor absent rank 20, base+0x30, saves offending pc
// (RULE14) supervisor call rank 21, base+0x100, saves call pc plus 2
// (RULE15) data address faults read 22 base+0x34, write 23 base+0x38
// (RULE16) dtlb misses read 24 base+0x60, write 25 base+0x70
// (RULE17) dtlb protection read 26 base+0x3c, write 27 base+0x40
// (RULE18) page-modified slot 28 at 0x44 reserved, never raised
// (RULE19) offset handlers add offset to vector base at system register 4
// (RULE20) interrupt entry pushes r8-r12, return address and status register
// (RULE21) several pending: take lowest priority number, leave the rest pending
module epv_event_vector (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        ext_reset_req,
    input  wire        dbg_halt_req,
    input  wire [31:0] dbg_halt_addr,
    input  wire        unrecov_req,
    input  wire        multihit_req,
    input  wire        berr_data_req,
    input  wire        berr_insn_req,
    input  wire        nmi_req,
    input  wire [3:0]  irq_req,
    input  wire [31:0] irq_autovector,
    input  wire        insn_addr_req,
    input  wire        itlb_miss_req,
    input  wire        itlb_prot_req,
    input  wire        breakpt_req,
    input  wire        illegal_req,
    input  wire        unimpl_req,
    input  wire        priv_req,
    input  wire        coproc_req,
    input  wire        scall_req,
    input  wire        daddr_rd_req,
    input  wire        daddr_wr_req,
    input  wire        dtlb_miss_rd_req,
    input  wire        dtlb_miss_wr_req,
    input  wire        dtlb_prot_rd_req,
    input  wire        dtlb_prot_wr_req,
    input  wire [31:0] first_nc_pc,
    input  wire [31:0] offend_pc,
    input  wire        sr_wr_en,
    input  wire [7:0]  sr_wr_addr,
    input  wire [31:0] sr_wr_data,
    input  wire        take_ready,
    input  wire        push_ready,
    output reg         take_valid_ff,
    output reg  [4:0]  take_event_ff,
    output reg  [31:0] handler_addr_ff,
    output reg  [31:0] return_addr_ff,
    output reg         return_valid_ff,
    output reg  [31:0] pending_ff,
    output reg  [31:0] exception_vector_base_ff,
    output wire        push_valid_ff,
    output wire [2:0]  push_sel_ff,
    output wire        push_busy_ff
);
    reg  [27:0] pend_ff;
    reg  [27:0] raw_req;
    reg  [27:0] nxt_pend;
    reg  [4:0]  win_idx;
    reg         win_any;
    reg  [31:0] win_off;
    reg  [1:0]  win_ra;
    reg  [31:0] nxt_handler;
    reg  [31:0] nxt_return;
    wire        grant;
    wire        win_is_irq;

    // handler offset of each slot; irq and debug slots are not offset based
    function [31:0] slot_offset;
        input [4:0] idx;
        begin
            case (idx)
                `EPV_EV_UNRECOV:      slot_offset = `EPV_OFF_UNRECOV;
                `EPV_EV_MULTIHIT:     slot_offset = `EPV_OFF_MULTIHIT;
                `EPV_EV_BERR_DATA:    slot_offset = `EPV_OFF_BERR_DATA;
                `EPV_EV_BERR_INSN:    slot_offset = `EPV_OFF_BERR_INSN;
                `EPV_EV_NMI:          slot_offset = `EPV_OFF_NMI;
                `EPV_EV_INSN_ADDR:    slot_offset = `EPV_OFF_INSN_ADDR;
                `EPV_EV_ITLB_MISS:    slot_offset = `EPV_OFF_ITLB_MISS;
                `EPV_EV_ITLB_PROT:    slot_offset = `EPV_OFF_ITLB_PROT;
                `EPV_EV_BREAKPT:      slot_offset = `EPV_OFF_BREAKPT;
                `EPV_EV_ILLEGAL:      slot_offset = `EPV_OFF_ILLEGAL;
                `EPV_EV_UNIMPL:       slot_offset = `EPV_OFF_UNIMPL;
                `EPV_EV_PRIV:         slot_offset = `EPV_OFF_PRIV;
                `EPV_EV_FPU:          slot_offset = `EPV_OFF_FPU;
                `EPV_EV_COPROC:       slot_offset = `EPV_OFF_COPROC;
                `EPV_EV_SCALL:        slot_offset = `EPV_OFF_SCALL;
                `EPV_EV_DADDR_RD:     slot_offset = `EPV_OFF_DADDR_RD;
                `EPV_EV_DADDR_WR:     slot_offset = `EPV_OFF_DADDR_WR;
                `EPV_EV_DTLB_MISS_RD: slot_offset = `EPV_OFF_DMISS_RD;
                `EPV_EV_DTLB_MISS_WR: slot_offset = `EPV_OFF_DMISS_WR;
                `EPV_EV_DTLB_PROT_RD: slot_offset = `EPV_OFF_DPROT_RD;
                `EPV_EV_DTLB_PROT_WR: slot_offset = `EPV_OFF_DPROT_WR;
                `EPV_EV_DTLB_MOD:     slot_offset = `EPV_OFF_DTLB_MOD;
                default:              slot_offset = 32'h0000_0000;
            endcase
        end
    endfunction

    // which return address each slot saves
    function [1:0] slot_ra;
        input [4:0] idx;
        begin
            case (idx)
                `EPV_EV_RESET, `EPV_EV_MULTIHIT, `EPV_EV_ITLB_MISS,
                `EPV_EV_DTLB_MISS_RD, `EPV_EV_DTLB_MISS_WR,
                `EPV_EV_FPU, `EPV_EV_DTLB_MOD:
                    slot_ra = `EPV_RA_NONE;
                `EPV_EV_UNRECOV, `EPV_EV_INSN_ADDR, `EPV_EV_ITLB_PROT,
                `EPV_EV_ILLEGAL, `EPV_EV_UNIMPL, `EPV_EV_PRIV, `EPV_EV_COPROC,
                `EPV_EV_DADDR_RD, `EPV_EV_DADDR_WR,
                `EPV_EV_DTLB_PROT_RD, `EPV_EV_DTLB_PROT_WR:
                    slot_ra = `EPV_RA_OFFEND;
                `EPV_EV_SCALL:
                    slot_ra = `EPV_RA_SCALL;
                default:
                    slot_ra = `EPV_RA_FIRST_NC;
            endcase
        end
    endfunction

    // interrupt slots are autovectored and open a context push
    function is_irq_slot;
        input [4:0] idx;
        begin
            is_irq_slot = (idx >= `EPV_EV_IRQ3) && (idx <= `EPV_EV_IRQ0);
        end
    endfunction

    // gather requests in priority order; reserved slots tied off
    always @* begin
        raw_req = 28'h0;
        raw_req[`EPV_EV_RESET]       = ext_reset_req;    // RULE1
        raw_req[`EPV_EV_DBG_HALT]    = dbg_halt_req;     // RULE2
        raw_req[`EPV_EV_UNRECOV]     = unrecov_req;      // RULE3
        raw_req[`EPV_EV_MULTIHIT]    = multihit_req;     // RULE4
        raw_req[`EPV_EV_BERR_DATA]   = berr_data_req;    // RULE5
        raw_req[`EPV_EV_BERR_INSN]   = berr_insn_req;    // RULE5
        raw_req[`EPV_EV_NMI]         = nmi_req;          // RULE6
        raw_req[10:7]                = {irq_req[0], irq_req[1], irq_req[2], irq_req[3]}; // RULE7
        raw_req[`EPV_EV_INSN_ADDR]   = insn_addr_req;    // RULE8
        raw_req[`EPV_EV_ITLB_MISS]   = itlb_miss_req;    // RULE9
        raw_req[`EPV_EV_ITLB_PROT]   = itlb_prot_req;    // RULE9
        raw_req[`EPV_EV_BREAKPT]     = breakpt_req;      // RULE10
        raw_req[`EPV_EV_ILLEGAL]     = illegal_req;      // RULE11
        raw_req[`EPV_EV_UNIMPL]      = unimpl_req;       // RULE11
        raw_req[`EPV_EV_PRIV]        = priv_req;         // RULE11
        raw_req[`EPV_EV_FPU]         = 1'b0;             // RULE12
        raw_req[`EPV_EV_COPROC]      = coproc_req;       // RULE13
        raw_req[`EPV_EV_SCALL]       = scall_req;        // RULE14
        raw_req[`EPV_EV_DADDR_RD]    = daddr_rd_req;     // RULE15
        raw_req[`EPV_EV_DADDR_WR]    = daddr_wr_req;     // RULE15
        raw_req[`EPV_EV_DTLB_MISS_RD] = dtlb_miss_rd_req; // RULE16
        raw_req[`EPV_EV_DTLB_MISS_WR] = dtlb_miss_wr_req; // RULE16
        raw_req[`EPV_EV_DTLB_PROT_RD] = dtlb_prot_rd_req; // RULE17
        raw_req[`EPV_EV_DTLB_PROT_WR] = dtlb_prot_wr_req; // RULE17
        raw_req[`EPV_EV_DTLB_MOD]    = 1'b0;             // RULE18
    end

    // lowest index wins; scanning downward keeps the last hit the smallest
    always @* begin : pick
        integer i;
        i       = 0;
        win_idx = 5'h0;
        win_any = 1'b0;
        for (i = `EPV_NUM_EVT - 1; i >= 0; i = i - 1) begin
            if (pend_ff[i]) begin
                win_idx = i[4:0]; // RULE21
                win_any = 1'b1;
            end
        end
    end

    // a new event is not presented while the context push is still running
    assign grant      = win_any && !take_valid_ff && !push_busy_ff;
    assign win_is_irq = is_irq_slot(win_idx);

    // handler and return address of the winner
    always @* begin
        win_off = slot_offset(win_idx);
        win_ra  = slot_ra(win_idx);
        if (win_idx == `EPV_EV_RESET) begin
            nxt_handler = `EPV_RESET_ADDR; // RULE1
        end else if (win_idx == `EPV_EV_DBG_HALT) begin
            nxt_handler = dbg_halt_addr; // RULE2
        end else if (win_is_irq) begin
            nxt_handler = irq_autovector; // RULE7
        end else begin
            nxt_handler = exception_vector_base_ff + win_off; // RULE19
        end
        case (win_ra)
            `EPV_RA_FIRST_NC: nxt_return = first_nc_pc;
            `EPV_RA_OFFEND:   nxt_return = offend_pc;
            `EPV_RA_SCALL:    nxt_return = offend_pc + `EPV_SCALL_RET_INC; // RULE14
            default:          nxt_return = 32'h0000_0000;
        endcase
    end

    // pending set; a new request beats the clear of the slot being taken
    always @* begin
        nxt_pend = pend_ff;
        if (grant) begin
            nxt_pend[win_idx] = 1'b0; // RULE21
        end
        nxt_pend = nxt_pend | raw_req;
    end

    // pending flags, offered event and vector base register
    always @(posedge ref_clk) begin
        if (rst) begin
            pend_ff                  <= 28'h0;
            pending_ff               <= 32'h0;
            take_valid_ff            <= 1'b0;
            take_event_ff            <= 5'h0;
            handler_addr_ff          <= 32'h0;
            return_addr_ff           <= 32'h0;
            return_valid_ff          <= 1'b0;
            exception_vector_base_ff <= `EPV_VBASE_RST;
        end else begin
            pend_ff    <= nxt_pend;
            pending_ff <= {4'h0, nxt_pend};
            if (sr_wr_en && sr_wr_addr == `EPV_SR_VBASE_ADDR) begin
                exception_vector_base_ff <= sr_wr_data; // RULE19
            end
            if (take_valid_ff && take_ready) begin
                take_valid_ff <= 1'b0;
            end else if (grant) begin
                take_valid_ff   <= 1'b1;
                take_event_ff   <= win_idx;
                handler_addr_ff <= nxt_handler;
                return_addr_ff  <= nxt_return;
                return_valid_ff <= (win_ra != `EPV_RA_NONE);
            end
        end
    end

    // context push starts when an interrupt entry is accepted
    epv_push_seq u_push (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .start         (take_valid_ff && take_ready && is_irq_slot(take_event_ff)), // RULE20
        .push_ready    (push_ready),
        .push_valid_ff (push_valid_ff),
        .push_sel_ff   (push_sel_ff),
        .busy_ff       (push_busy_ff)
    );
endmodule // epv_event_vector

// [pkg/epv_defines.vh]
`ifndef EPV_DEFINES_VH
`define EPV_DEFINES_VH

// number of event slots, priority 1 is index 0
`define EPV_NUM_EVT        28
`define EPV_RESET_ADDR     32'h8000_0000
// system-register address of the vector base
`define EPV_SR_VBASE_ADDR  8'h04
`define EPV_VBASE_RST      32'h0000_0000

// event indices (priority minus one)
`define EPV_EV_RESET       5'd0
`define EPV_EV_DBG_HALT    5'd1
`define EPV_EV_UNRECOV     5'd2
`define EPV_EV_MULTIHIT    5'd3
`define EPV_EV_BERR_DATA   5'd4
`define EPV_EV_BERR_INSN   5'd5
`define EPV_EV_NMI         5'd6
`define EPV_EV_IRQ3        5'd7
`define EPV_EV_IRQ0        5'd10
`define EPV_EV_INSN_ADDR   5'd11
`define EPV_EV_ITLB_MISS   5'd12
`define EPV_EV_ITLB_PROT   5'd13
`define EPV_EV_BREAKPT     5'd14
`define EPV_EV_ILLEGAL     5'd15
`define EPV_EV_UNIMPL      5'd16
`define EPV_EV_PRIV        5'd17
`define EPV_EV_FPU         5'd18
`define EPV_EV_COPROC      5'd19
`define EPV_EV_SCALL       5'd20
`define EPV_EV_DADDR_RD    5'd21
`define EPV_EV_DADDR_WR    5'd22
`define EPV_EV_DTLB_MISS_RD 5'd23
`define EPV_EV_DTLB_MISS_WR 5'd24
`define EPV_EV_DTLB_PROT_RD 5'd25
`define EPV_EV_DTLB_PROT_WR 5'd26
`define EPV_EV_DTLB_MOD    5'd27

// handler offsets from the vector base
`define EPV_OFF_UNRECOV    32'h0000_0000
`define EPV_OFF_MULTIHIT   32'h0000_0004
`define EPV_OFF_BERR_DATA  32'h0000_0008
`define EPV_OFF_BERR_INSN  32'h0000_000c
`define EPV_OFF_NMI        32'h0000_0010
`define EPV_OFF_INSN_ADDR  32'h0000_0014
`define EPV_OFF_ITLB_PROT  32'h0000_0018
`define EPV_OFF_BREAKPT    32'h0000_001c
`define EPV_OFF_ILLEGAL    32'h0000_0020
`define EPV_OFF_UNIMPL     32'h0000_0024
`define EPV_OFF_PRIV       32'h0000_0028
`define EPV_OFF_FPU        32'h0000_002c
`define EPV_OFF_COPROC     32'h0000_0030
`define EPV_OFF_DADDR_RD   32'h0000_0034
`define EPV_OFF_DADDR_WR   32'h0000_0038
`define EPV_OFF_DPROT_RD   32'h0000_003c
`define EPV_OFF_DPROT_WR   32'h0000_0040
`define EPV_OFF_DTLB_MOD   32'h0000_0044
`define EPV_OFF_ITLB_MISS  32'h0000_0050
`define EPV_OFF_DMISS_RD   32'h0000_0060
`define EPV_OFF_DMISS_WR   32'h0000_0070
`define EPV_OFF_SCALL      32'h0000_0100
`define EPV_SCALL_RET_INC  32'h0000_0002

// return-address kinds
`define EPV_RA_NONE        2'd0
`define EPV_RA_FIRST_NC    2'd1
`define EPV_RA_OFFEND      2'd2
`define EPV_RA_SCALL       2'd3

// stack push: r8..r12, return address, status = 7 words
`define EPV_PUSH_WORDS     3'd7
`define EPV_PUSH_LAST      3'd6

`endif

// [verilog/epv_push_seq.v]
`include "epv_defines.vh"

// walks the seven-word context push for interrupt entry
module epv_push_seq (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        start,
    input  wire        push_ready,
    output reg         push_valid_ff,
    output reg  [2:0]  push_sel_ff,
    output reg         busy_ff
);
    reg [2:0] nxt_push_sel;
    reg       nxt_busy;

    // sel 0..4 = r8..r12, 5 = return address, 6 = status register
    always @* begin
        nxt_busy     = busy_ff;
        nxt_push_sel = push_sel_ff;
        if (!busy_ff && start) begin
            nxt_busy     = 1'b1;
            nxt_push_sel = 3'h0;
        end else if (busy_ff && push_ready) begin
            if (push_sel_ff == `EPV_PUSH_LAST) begin
                nxt_busy = 1'b0;
            end else begin
                nxt_push_sel = push_sel_ff + 3'h1;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            busy_ff       <= 1'b0;
            push_sel_ff   <= 3'h0;
            push_valid_ff <= 1'b0;
        end else begin
            busy_ff       <= nxt_busy;
            push_sel_ff   <= nxt_push_sel;
            push_valid_ff <= nxt_busy;
        end
    end
endmodule // epv_push_seq

// [verification/epv_event_vector_asserts.sv]
module epv_event_vector_asserts (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        take_ready,
    input wire logic        push_ready,
    input wire logic        take_valid_ff,
    input wire logic [4:0]  take_event_ff,
    input wire logic [31:0] handler_addr_ff,
    input wire logic        return_valid_ff,
    input wire logic [31:0] pending_ff,
    input wire logic        push_valid_ff,
    input wire logic [2:0]  push_sel_ff,
    input wire logic        push_busy_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // an accepted offer, and one that opens an interrupt context push
    wire acc = take_valid_ff && take_ready;
    wire irq_acc = acc && take_event_ff >= 5'd7 && take_event_ff <= 5'd10;

    AST_RESET_QUIET: assert property ($past(rst) |-> !take_valid_ff && pending_ff == 32'h0)
        else $error("outputs not quiet after reset");
    AST_RSVD_PEND: assert property (pending_ff[18] == 1'b0 && pending_ff[31:27] == 5'h0)
        else $error("reserved slot pending");
    AST_RSVD_OFFER: assert property (take_valid_ff |-> take_event_ff != 5'd18 && take_event_ff != 5'd27)
        else $error("reserved slot offered");
    AST_RESET_VEC: assert property (take_valid_ff && take_event_ff == 5'd0 |-> handler_addr_ff == 32'h8000_0000 && !return_valid_ff)
        else $error("reset handler or return wrong");
    AST_MISS_NORET: assert property (take_valid_ff && (take_event_ff == 5'd12 || take_event_ff == 5'd23 || take_event_ff == 5'd24) |-> !return_valid_ff)
        else $error("miss carries a return address");
    AST_OFFER_HOLD: assert property (take_valid_ff && !take_ready |=> take_valid_ff && $stable(take_event_ff) && $stable(handler_addr_ff))
        else $error("offer changed before acceptance");
    AST_OFFER_GAP: assert property (acc |=> !take_valid_ff)
        else $error("no idle cycle after accepted offer");
    AST_IRQ_PUSH: assert property (irq_acc |-> ##[1:2] push_busy_ff)
        else $error("interrupt entry without context push");
    AST_PUSH_FIRST: assert property ($rose(push_busy_ff) |-> ##[0:2] (push_valid_ff && push_sel_ff == 3'd0))
        else $error("push does not start at first register");
    AST_PUSH_HOLD: assert property (push_valid_ff && !push_ready |=> push_valid_ff && $stable(push_sel_ff))
        else $error("push word changed while stalled");
    AST_PUSH_BLOCK: assert property (push_busy_ff |-> !take_valid_ff)
        else $error("offer made during context push");

    // main scenarios reached
    COV_IRQ: cover property (irq_acc);
    COV_SCALL: cover property (acc && take_event_ff == 5'd20);
    COV_PUSH_DONE: cover property (push_valid_ff && push_ready && push_sel_ff == 3'd6);
endmodule // epv_event_vector_asserts

bind epv_event_vector epv_event_vector_asserts u_chk (.ref_clk, .rst, .take_ready, .push_ready,
    .take_valid_ff, .take_event_ff, .handler_addr_ff, .return_valid_ff, .pending_ff,
    .push_valid_ff, .push_sel_ff, .push_busy_ff);

// [verification/epv_pipe_model.sv]
module epv_pipe_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      take_ready = 1'b0,
    output logic      push_ready = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_ff = 2'd0;

    // slow mode accepts one cycle in three so offers and pushes are held under stall
    always @(posedge ref_clk) begin
        ph_ff      <= (rst || ph_ff == 2'd2) ? 2'd0 : ph_ff + 2'd1;
        take_ready <= !rst && (!slow || ph_ff == 2'd1);
        push_ready <= !rst && (!slow || ph_ff == 2'd0);
    end
endmodule // epv_pipe_model

// [verification/epv_event_vector_tb_top.sv]
`include "epv_defines.vh"
module epv_event_vector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] ev; logic [31:0] ha; logic [31:0] ra; logic [1:0] rk;} epv_exp_t;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        slow    = 1'b0;
    logic        sw_en   = 1'b0;
    logic [7:0]  swa     = 8'h00;
    logic [31:0] rq = 32'h0, dbg_addr = 32'h0, autovec = 32'h0, fnc = 32'h0, off = 32'h0;
    logic [31:0] swd = 32'h0, base_exp = 32'h0;
    wire         take_ready, push_ready, take_valid_ff, return_valid_ff;
    wire         push_valid_ff, push_busy_ff;
    wire [4:0]   take_event_ff;
    wire [2:0]   push_sel_ff;
    wire [31:0]  handler_addr_ff, return_addr_ff, pending_ff, base;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          n_push = 0;
    epv_exp_t    q[$];
    epv_exp_t    cur;
    // handler offsets and return kinds (0 none, 1 first open, 2 offender, 3 call plus two)
    logic [11:0] offs [28] = '{12'h000, 12'h000, 12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
        12'h000, 12'h000, 12'h000, 12'h000, 12'h014, 12'h050, 12'h018, 12'h01c, 12'h020,
        12'h024, 12'h028, 12'h02c, 12'h030, 12'h100, 12'h034, 12'h038, 12'h060, 12'h070,
        12'h03c, 12'h040, 12'h044};
    logic [1:0]  rk [28] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd1, 2'd1, 2'd1, 2'd1, 2'd1, 2'd1, 2'd1,
        2'd2, 2'd0, 2'd2, 2'd1, 2'd2, 2'd2, 2'd2, 2'd0, 2'd2, 2'd3, 2'd2, 2'd2, 2'd0, 2'd0,
        2'd2, 2'd2, 2'd0};

    epv_event_vector u_dut (.ref_clk, .rst, .ext_reset_req(rq[0]), .dbg_halt_req(rq[1]),
        .dbg_halt_addr(dbg_addr), .unrecov_req(rq[2]), .multihit_req(rq[3]),
        .berr_data_req(rq[4]), .berr_insn_req(rq[5]), .nmi_req(rq[6]),
        .irq_req({rq[7], rq[8], rq[9], rq[10]}), .irq_autovector(autovec),
        .insn_addr_req(rq[11]), .itlb_miss_req(rq[12]), .itlb_prot_req(rq[13]),
        .breakpt_req(rq[14]), .illegal_req(rq[15]), .unimpl_req(rq[16]), .priv_req(rq[17]),
        .coproc_req(rq[19]), .scall_req(rq[20]), .daddr_rd_req(rq[21]),
        .daddr_wr_req(rq[22]), .dtlb_miss_rd_req(rq[23]), .dtlb_miss_wr_req(rq[24]),
        .dtlb_prot_rd_req(rq[25]), .dtlb_prot_wr_req(rq[26]), .first_nc_pc(fnc),
        .offend_pc(off), .sr_wr_en(sw_en), .sr_wr_addr(swa), .sr_wr_data(swd), .take_ready,
        .push_ready, .take_valid_ff, .take_event_ff, .handler_addr_ff, .return_addr_ff,
        .return_valid_ff, .pending_ff, .exception_vector_base_ff(base), .push_valid_ff,
        .push_sel_ff, .push_busy_ff);

    epv_pipe_model u_pipe (.ref_clk, .rst, .slow, .take_ready, .push_ready);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic sr_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        sw_en <= 1'b1;
        swa   <= a;
        swd   <= d;
        @(posedge ref_clk);
        sw_en <= 1'b0;
    endtask

    // reset, then program the vector base; a write to another register must not land
    task automatic restart();
        rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(base, 32'h0);
        chk(pending_ff, 32'h0);
        base_exp = $urandom & 32'hffff_fffc;
        sr_write(`EPV_SR_VBASE_ADDR, base_exp);
        sr_write(8'h08, ~base_exp);
        repeat (2) @(posedge ref_clk);
        chk(base, base_exp);
    endtask

    // raise a set of events in one cycle; they must come out lowest index first
    task automatic fire(input logic [31:0] m);
        epv_exp_t e;
        int       n;
        @(posedge ref_clk);
        fnc      <= $urandom;
        off      <= $urandom;
        dbg_addr <= $urandom;
        autovec  <= $urandom;
        slow     <= $urandom % 2;
        @(posedge ref_clk);
        for (int i = 0; i < 28; i++) begin
            if (m[i]) begin
                e.ev = i[4:0];
                e.rk = rk[i];
                e.ha = (i == 0) ? `EPV_RESET_ADDR : (i == 1) ? dbg_addr
                     : (i >= 7 && i <= 10) ? autovec : base_exp + {20'h0, offs[i]};
                e.ra = (rk[i] == 2'd1) ? fnc : (rk[i] == 2'd3) ? off + `EPV_SCALL_RET_INC : off;
                q.push_back(e);
            end
        end
        n = n_push + 7 * $countones(m[10:7]);
        rq <= m;
        @(posedge ref_clk);
        rq <= 32'h0;
        @(posedge ref_clk);
        chk(pending_ff, m);
        for (int k = 0; k < 2000 && q.size() != 0; k++)
            @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        for (int k = 0; k < 100 && push_busy_ff !== 1'b0; k++)
            @(posedge ref_clk);
        chk(n_push, n);
        chk(q.size(), 0);
    endtask

    // watch accepted offers and pushes against the oldest noted expectation
    always @(posedge ref_clk) begin
        if (!rst && take_valid_ff === 1'b1 && take_ready === 1'b1) begin
            if (q.size() == 0)
                chk(32'h1, 32'h0);
            else begin
                cur = q.pop_front();
                chk(take_event_ff, cur.ev);
                chk(handler_addr_ff, cur.ha);
                if (cur.rk != 2'd0) chk(return_addr_ff, cur.ra);
                if (cur.ev != 5'd3) chk(return_valid_ff, cur.rk != 2'd0);
            end
        end
        if (!rst && push_valid_ff === 1'b1 && push_ready === 1'b1) begin
            chk(push_sel_ff, n_push % 7);
            n_push++;
        end
    end

    // clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // hang guard, far beyond the expected few thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end

    // main sequence: every event alone, then random and full sets after a second reset
    initial begin
        int seed;
        seed = $urandom(32'h6f86);
        restart();
        for (int i = 0; i < 27; i++) begin
            if (i != 18) fire(32'h1 << i);
        end
        restart();
        fire(32'h07fb_ffff);
        repeat (12) fire($urandom & 32'h07fb_ffff);
        summarize();
    end
endmodule // epv_event_vector_tb_top
